// ### hdl/cmtu_top.sv
// Two-unit, four-channel match timer with register port and request outputs
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "cmtu_regs.svh"
// Overview of operation
// R1 - Each channel counts up sixteen bits per tick
// R2 - Tick is clock divided by 8/32/128/512
// R3 - Select 00 is /8, 11 is /512
// R4 - Software writes counter; zero restarts from zero
// R5 - Period is constant plus one ticks
// R6 - Equal to constant: match, then zero
// R7 - Run bit starts; clear halts, keeps value
// R8 - Enable bit gates the match request
// R9 - No local flag; request is a pulse; the code also keeps the sticky status stat_r, which drives IRQ
// R10 - Controller clears its pending flag on accept
// R11 - Group flag stays set, later requests unaffected
// R12 - Reset leaves units stopped until released
// R13 - Match also requests transfer and DMA activation
// R14 - Two units, four channels, own registers
// R15 - Software stops and clears before reconfiguring
module cmtu_top (
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic [7:0]  ADDR,
   input  wire logic [15:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [15:0]      RDATA,
   output logic             IRQ,
   output logic [3:0]       MATCH_IRQ_REQ,
   output logic [3:0]       DTC_REQ,
   output logic [3:0]       DMA_REQ
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [1:0]  stop_r;          // Unit stop bits, one per unit
   logic [3:0]  start_r;         // Run bits, two per unit
   logic [1:0]  cks_r [4];       // Clock select per channel
   logic [3:0]  ie_r;            // Match request enable per channel
   logic [15:0] const_r [4];     // Match constant per channel
   logic [15:0] ch_cnt [4];      // Counter value per channel
   logic [3:0]  ch_match;        // Match pulse per channel
   logic [3:0]  ch_en;           // Channel counting
   logic [3:0]  cnt_we;          // Counter write strobes
   logic [3:0]  stat_r;          // Sticky interrupt status
   logic [3:0]  stat_nxt;        // Next status value
   logic [3:0]  mask_r;          // Interrupt mask, one enables
   logic [3:0]  stat_clr;        // Write-one-to-clear pattern
   logic [15:0] rd_mux;          // Read data before the register

   // True when the address falls in the page of channel m
   function automatic logic chan_hit(input logic [7:0] a, input int m);
      chan_hit = (a[7:4] == 4'(`CMTU_CH0_PAGE + m));
   endfunction

   // True when channel m may be reached: its unit has a clock
   function automatic logic chan_live(input logic [1:0] stop, input int m);
      chan_live = !stop[m / 2];
   endfunction

   // ----------------------------------------------------------------
   // Unit stop control
   // ----------------------------------------------------------------
   // Both units come out of reset stopped; only software releases them
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         stop_r <= `CMTU_STOP_RST; // R12
      end else if (WR && (ADDR == `CMTU_STOP_OFS)) begin
         stop_r <= WDATA[1:0]; // R12
      end
   end

   // ----------------------------------------------------------------
   // Start registers
   // ----------------------------------------------------------------
   // A stopped unit has no clock, so its start register ignores writes
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         start_r <= 4'h0;
      end else begin
         if (WR && (ADDR == `CMTU_START0_OFS) && !stop_r[0]) begin
            start_r[1:0] <= WDATA[1:0]; // R7
         end
         if (WR && (ADDR == `CMTU_START1_OFS) && !stop_r[1]) begin
            start_r[3:2] <= WDATA[1:0]; // R7
         end
      end
   end

   // Counting needs both the run bit and a clocked unit
   always_comb begin
      for (int m = 0; m < 4; m++) begin
         ch_en[m] = start_r[m] && chan_live(stop_r, m); // R7 R12
      end
   end

   // ----------------------------------------------------------------
   // Channel control and constant registers
   // ----------------------------------------------------------------
   // Each channel owns its control and constant words
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int m = 0; m < 4; m++) begin
            cks_r[m]   <= 2'b00;
            const_r[m] <= `CMTU_CONST_RST;
         end
         ie_r <= 4'h0;
      end else begin
         for (int m = 0; m < 4; m++) begin
            if (WR && chan_hit(ADDR, m) && chan_live(stop_r, m)) begin
               // Control word: clock select and request enable
               if (ADDR[3:0] == `CMTU_CTRL_SUB) begin
                  cks_r[m] <= WDATA[`CMTU_CTRL_CKS_LSB +: 2]; // R3
                  ie_r[m]  <= WDATA[`CMTU_CTRL_IE_BIT]; // R8
               end
               // Constant word, taken as period minus one
               if (ADDR[3:0] == `CMTU_CONST_SUB) begin
                  const_r[m] <= WDATA; // R5
               end
            end
         end
      end
   end

   // Counter writes go straight into the channel
   always_comb begin
      for (int m = 0; m < 4; m++) begin
         cnt_we[m] = WR && chan_hit(ADDR, m) && chan_live(stop_r, m) &&
                     (ADDR[3:0] == `CMTU_CNT_SUB); // R4
      end
   end

   // ----------------------------------------------------------------
   // Channels
   // ----------------------------------------------------------------
   // Four identical channels, two per unit
   for (genvar g = 0; g < 4; g++) begin : g_ch
      cmtu_channel u_ch (
         .clk         (MCLK),
         .rst_n       (RST_N),
         .en          (ch_en[g]),
         .clock_select         (cks_r[g]),
         .cnt_we      (cnt_we[g]),
         .cnt_wdata   (WDATA),
         .match_const (const_r[g]),
         .count       (ch_cnt[g]),
         .match       (ch_match[g])
      ); // R14
   end

   // ----------------------------------------------------------------
   // Request outputs
   // ----------------------------------------------------------------
   // Request pulses only; the pending flag lives in the controller
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         MATCH_IRQ_REQ <= 4'h0;
      end else begin
         MATCH_IRQ_REQ <= ch_match & ie_r; // R8 R9
      end
   end

   // Activation requests follow every match, enabled or not
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         DTC_REQ <= 4'h0;
         DMA_REQ <= 4'h0;
      end else begin
         DTC_REQ <= ch_match; // R13
         DMA_REQ <= ch_match; // R13
      end
   end

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   // Write-one-to-clear pattern, only on a status write
   assign stat_clr = (WR && (ADDR == `CMTU_STAT_OFS)) ? WDATA[3:0] : 4'h0;

   // A match in the clearing cycle survives: set wins over clear
   assign stat_nxt = (stat_r & ~stat_clr) | (ch_match & ie_r);

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         stat_r <= 4'h0;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // Mask resets closed so nothing interrupts before setup
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         mask_r <= 4'h0;
      end else if (WR && (ADDR == `CMTU_MASK_OFS)) begin
         mask_r <= WDATA[3:0];
      end
   end

   // Level output; computed from next state to stay a plain flop
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(stat_nxt & mask_r);
      end
   end

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   // Unmapped addresses and the channel registers of stopped units read as zero
   always_comb begin
      rd_mux = 16'h0000;
      case (ADDR)
         `CMTU_STOP_OFS:   rd_mux = {14'h0000, stop_r};
         `CMTU_START0_OFS: rd_mux = {14'h0000, start_r[1:0]};
         `CMTU_START1_OFS: rd_mux = {14'h0000, start_r[3:2]};
         `CMTU_STAT_OFS:   rd_mux = {12'h000, stat_r};
         `CMTU_MASK_OFS:   rd_mux = {12'h000, mask_r};
         default:          rd_mux = 16'h0000;
      endcase
      for (int m = 0; m < 4; m++) begin
         if (chan_hit(ADDR, m) && chan_live(stop_r, m)) begin
            case (ADDR[3:0])
               `CMTU_CTRL_SUB: begin
                  rd_mux[`CMTU_CTRL_CKS_LSB +: 2] = cks_r[m];
                  rd_mux[`CMTU_CTRL_IE_BIT]       = ie_r[m];
               end
               `CMTU_CNT_SUB:   rd_mux = ch_cnt[m];
               `CMTU_CONST_SUB: rd_mux = const_r[m];
               default:         rd_mux = 16'h0000;
            endcase
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         RDATA <= 16'h0000;
      end else if (RD) begin
         RDATA <= rd_mux;
      end else begin
         RDATA <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_req_gate;
      @(posedge MCLK) disable iff (!RST_N)
      (|(ch_match & ~ie_r)) |=> (MATCH_IRQ_REQ & ~$past(ie_r)) == 4'h0;
   endproperty
   a_req_gate: assert property (p_req_gate) else $error("request with enable clear"); // R8

   property p_req_pulse;
      @(posedge MCLK) disable iff (!RST_N)
      (|MATCH_IRQ_REQ) |=> (MATCH_IRQ_REQ & $past(MATCH_IRQ_REQ)) == 4'h0;
   endproperty
   a_req_pulse: assert property (p_req_pulse) else $error("request held past a cycle"); // R9

   property p_stop_idle;
      @(posedge MCLK) disable iff (!RST_N)
      stop_r[0] && $past(stop_r[0]) |=>
         $stable(ch_cnt[0]) && $stable(ch_cnt[1]) && (DTC_REQ[1:0] == 2'b00);
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("stopped unit active"); // R12

   property p_act_req;
      @(posedge MCLK) disable iff (!RST_N)
      (|ch_match) |=> (DTC_REQ == $past(ch_match)) && (DMA_REQ == $past(ch_match));
   endproperty
   a_act_req: assert property (p_act_req) else $error("activation request missing"); // R13

   property p_start;
      @(posedge MCLK) disable iff (!RST_N)
      WR && (ADDR == `CMTU_START1_OFS) && !stop_r[1] && WDATA[0] |=>
         ##8 (ch_cnt[2] != $past(ch_cnt[2], 8)) || cnt_we[2] || $past(cnt_we[2], 8) ||
         !start_r[2] || ($past(cks_r[2], 1) != 2'b00) || (const_r[2] == 16'h0000);
   endproperty
   a_start: assert property (p_start) else $error("started channel did not count"); // R7

   property p_stop_write;
      @(posedge MCLK) disable iff (!RST_N)
      stop_r[0] && WR && (ADDR == `CMTU_START0_OFS) |=> $stable(start_r[1:0]);
   endproperty
   a_stop_write: assert property (p_stop_write) else $error("stopped unit took a start"); // R12

   property p_live_read;
      @(posedge MCLK) disable iff (!RST_N)
      RD && stop_r[0] && (ADDR[7:5] == 3'b001) |=> RDATA == 16'h0000;
   endproperty
   a_live_read: assert property (p_live_read) else $error("stopped unit read nonzero"); // R12

   property p_stat_set;
      @(posedge MCLK) disable iff (!RST_N)
      (|MATCH_IRQ_REQ) |-> (stat_r & MATCH_IRQ_REQ) == MATCH_IRQ_REQ;
   endproperty
   a_stat_set: assert property (p_stat_set) else $error("request without status"); // R8

   property p_req_zero;
      @(posedge MCLK) disable iff (!RST_N)
      DTC_REQ[0] |-> $past(ch_cnt[0]) == 16'h0000;
   endproperty
   a_req_zero: assert property (p_req_zero) else $error("match left counter nonzero"); // R6

endmodule

// ### hdl/cmtu_regs.svh
// Register offsets, field positions, reset values and prescaler counts of the match timer
`ifndef CMTU_REGS_SVH
`define CMTU_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define CMTU_STOP_OFS      8'h00
`define CMTU_START0_OFS    8'h04
`define CMTU_START1_OFS    8'h08
`define CMTU_STAT_OFS      8'h0c
`define CMTU_MASK_OFS      8'h10
`define CMTU_CH0_PAGE      4'h2
`define CMTU_CTRL_SUB      4'h0
`define CMTU_CNT_SUB       4'h4
`define CMTU_CONST_SUB     4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CMTU_CTRL_CKS_LSB  0
`define CMTU_CTRL_IE_BIT   6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CMTU_STOP_RST      2'b11
`define CMTU_CONST_RST     16'hffff

// ----------------------------------------------------------------
// Prescaler terminal counts (ratio minus one)
// ----------------------------------------------------------------
`define CMTU_TERM_DIV8     9'h007
`define CMTU_TERM_DIV32    9'h01f
`define CMTU_TERM_DIV128   9'h07f
`define CMTU_TERM_DIV512   9'h1ff

`endif

// ### hdl/cmtu_pkg.sv
// Types and shared functions of the match timer
package cmtu_pkg;
`include "cmtu_regs.svh"

   // ----------------------------------------------------------------
   // Clock select encoding, ratios in ascending order
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CMTU_DIV8,
      CMTU_DIV32,
      CMTU_DIV128,
      CMTU_DIV512
   } cmtu_cks_type;

   typedef logic [15:0] cmtu_word_type;   // Counter and register word

   // Terminal count of the prescaler for a clock select value
   function automatic logic [8:0] cmtu_term(input logic [1:0] clock_select);
      case (cmtu_cks_type'(clock_select))
         CMTU_DIV8:   cmtu_term = `CMTU_TERM_DIV8;
         CMTU_DIV32:  cmtu_term = `CMTU_TERM_DIV32;
         CMTU_DIV128: cmtu_term = `CMTU_TERM_DIV128;
         default:     cmtu_term = `CMTU_TERM_DIV512;
      endcase
   endfunction
endpackage

// ### hdl/cmtu_channel.sv
// One match timer channel: prescaler, 16-bit up-counter and match detection
`timescale 1ns/1ps
module cmtu_channel (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        en,
   input  wire logic [1:0]  clock_select,
   input  wire logic        cnt_we,
   input  wire logic [15:0] cnt_wdata,
   input  wire logic [15:0] match_const,
   output logic [15:0]      count,
   output logic             match
);

   logic [8:0] pre_r;   // Prescaler divider count
   logic       tick;    // One count-clock tick

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Tick at the terminal count of the selected ratio
   assign tick = en && (pre_r == cmtu_pkg::cmtu_term(clock_select)); // R2 R3

   // Restarts when halted, so a fresh start never gives a short first tick
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 9'h000;
      end else if (!en || tick) begin
         pre_r <= 9'h000;
      end else begin
         pre_r <= pre_r + 9'h001;
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   // Software write wins over a tick in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
      end else if (cnt_we) begin
         count <= cnt_wdata; // R4
      end else if (tick) begin
         if (count == match_const) begin
            count <= 16'h0000; // R5 R6
         end else begin
            count <= count + 16'h0001; // R1
         end
      end
   end

   // Match pulse, one cycle, in the cycle the counter shows zero again
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         match <= 1'b0;
      end else begin
         match <= !cnt_we && tick && (count == match_const); // R6 R9
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_step;
      @(posedge clk) disable iff (!rst_n)
      tick && !cnt_we && (count != match_const) |=> count == $past(count) + 16'h0001;
   endproperty
   a_step: assert property (p_step) else $error("counter did not step by one"); // R1

   property p_tick_gap;
      @(posedge clk) disable iff (!rst_n)
      tick |=> (!tick)[*7];
   endproperty
   a_tick_gap: assert property (p_tick_gap) else $error("ticks closer than eight"); // R2

   property p_write;
      @(posedge clk) disable iff (!rst_n)
      cnt_we |=> count == $past(cnt_wdata);
   endproperty
   a_write: assert property (p_write) else $error("counter write lost"); // R4

   property p_match_zero;
      @(posedge clk) disable iff (!rst_n)
      match |-> (count == 16'h0000) && ($past(count) == $past(match_const));
   endproperty
   a_match_zero: assert property (p_match_zero) else $error("match without clear"); // R6

   property p_hold;
      @(posedge clk) disable iff (!rst_n)
      !en && !cnt_we |=> $stable(count) && !match;
   endproperty
   a_hold: assert property (p_hold) else $error("halted counter moved"); // R7

endmodule

// ### testbench/cmtu_intc_model.sv
// Interrupt controller model that takes the timer's match requests
`timescale 1ns/1ps
module cmtu_intc_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [3:0] req,
   input  wire logic [3:0] slow,
   output logic [3:0]      pend_r,
   output logic            grp_r,
   output logic [7:0]      taken_r
);
   // ----------------------------------------------------------------
   // Pending flags and acceptance
   // ----------------------------------------------------------------
   logic [1:0] dly_r [4];   // Cycles left before a pending request is accepted

   // A slow channel waits three cycles before acceptance, a prompt one none.
   // Two acceptances in one cycle count once: the bench only tests for any.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_r  <= 4'h0;
         taken_r <= 8'h00;
         for (int i = 0; i < 4; i++) dly_r[i] <= 2'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (req[i]) begin
               pend_r[i] <= 1'b1;
               dly_r[i]  <= slow[i] ? 2'h3 : 2'h0;
            end else if (pend_r[i] && dly_r[i] != 2'h0) begin
               dly_r[i] <= dly_r[i] - 2'h1;
            end else if (pend_r[i]) begin
               pend_r[i] <= 1'b0;
               taken_r   <= taken_r + 8'h01;
            end
         end
      end
   end

   // Group flag is sticky and never blocks later requests
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         grp_r <= 1'b0;
      end else begin
         grp_r <= grp_r | (|req);
      end
   end
endmodule

// ### testbench/tb_compare_match_timer_unit.sv
// Self-checking bench of the four-channel match timer
`timescale 1ns/1ps
module tb_compare_match_timer_unit;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic        mclk  = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr  = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic        wr    = 1'b0;
   logic        rd    = 1'b0;
   logic [3:0]  slow  = 4'h0;   // Partner acceptance speed per channel
   logic [15:0] rdata;
   logic        irq;
   logic [3:0]  mreq;
   logic [3:0]  data_transfer_controller;
   logic [3:0]  dma;
   logic [3:0]  pend;
   logic        grp;
   logic [7:0]  taken;
   logic [15:0] got;
   logic [15:0] a;
   int          err_count    = 0;
   int          total_checks = 0;
   int          c;
   int          n;
   int          p;

   always #50 mclk = ~mclk;

   cmtu_top cmtu_top_i (.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .IRQ(irq), .MATCH_IRQ_REQ(mreq), .DTC_REQ(data_transfer_controller), .DMA_REQ(dma));
   cmtu_intc_model cmtu_intc_model_i (.clk(mclk), .rst_n(rst_n), .req(mreq), .slow(slow),
      .pend_r(pend), .grp_r(grp), .taken_r(taken));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic int ratio(input int clock_select);
      return 8 << (2 * clock_select);
   endfunction

   function automatic logic [7:0] base(input int m);
      return 8'h20 + 8'(16 * m);
   endfunction

   task automatic check(input logic [15:0] act, input logic [15:0] exp, input string what);
      total_checks++;
      if (act !== exp) begin
         err_count++;
         $display("[ERR] %0t %s: got %h, expected %h", $time, what, act, exp);
      end
   endtask

   // One-cycle write strobe, dropped at the edge that takes it
   task automatic wrt(input logic [7:0] ad, input logic [15:0] d);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= ad;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rdr(input logic [7:0] ad, output logic [15:0] d);
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= ad;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask

   task automatic run(input int m, input logic on);
      wrt(m < 2 ? 8'h04 : 8'h08, on ? 16'(1 << (m % 2)) : 16'h0000);
   endtask

   // Waits for a transfer request; cyc counts from the cycle after the last one
   task automatic wait_pulse(input int m, input logic ie, output int cyc);
      cyc = 0;
      do begin
         @(negedge mclk);
         cyc++;
      end while (data_transfer_controller[m] !== 1'b1 && cyc < 40000);
      check(16'(dma[m]), 16'h0001, "dma request");
      check(16'(mreq[m]), 16'(ie), "gated match request");
      @(negedge mclk);
      check(16'(mreq[m] | data_transfer_controller[m]), 16'h0000, "request width");
   endtask

   task automatic complete_run;
      $display("Checks %0d, errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog: the tests need well under 20000 cycles
   // ----------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      complete_run;
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(29));
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      // Stopped units refuse writes and raise nothing
      rdr(8'h00, got);
      check(got, 16'h0003, "stop bits after reset");
      rdr(base(0) + 8'h08, got);
      check(got, 16'h0000, "stopped unit reads zero");
      wrt(8'h04, 16'h0001);
      repeat (40) @(posedge mclk);
      check(16'(data_transfer_controller), 16'h0000, "requests while stopped");
      wrt(8'h00, 16'h0000);
      rdr(8'h04, got);
      check(got, 16'h0000, "start write refused");
      rdr(base(1) + 8'h08, got);
      check(got, 16'hffff, "constant reset");
      wrt(8'h14, 16'hffff);
      rdr(8'h14, got);
      check(got, 16'h0000, "unmapped read");
      // Each channel with its own clock select and a random constant
      for (int k = 0; k < 4; k++) begin
         c = $urandom_range(3, 0);
         n = (k == 0) ? 0 : (k == 3) ? 1 : $urandom_range(1, 0);
         slow <= 4'($urandom);
         wrt(base(k) + 8'h04, 16'h0000);
         wrt(base(k) + 8'h08, 16'(c));
         wrt(base(k), 16'(k) | 16'(n << 6));
         wrt(8'h10, 16'h000f);
         run(k, 1'b1);
         wait_pulse(k, n[0], p);
         wait_pulse(k, n[0], p);
         // One cycle of the period is spent inside the previous wait
         check(16'(p), 16'((c + 1) * ratio(k) - 1), "match period");
         run(k, 1'b0);
         rdr(8'h0c, got);
         check(got, n ? 16'(1 << k) : 16'h0000, "status bit");
         check(16'(irq), 16'(n), "irq level");
         wrt(8'h10, 16'h0000);
         rdr(8'h0c, got);
         check(16'(irq), 16'h0000, "masked irq");
         wrt(8'h0c, 16'(1 << k));
         wrt(8'h10, 16'h000f);
         rdr(8'h0c, got);
         check(got, 16'h0000, "status cleared");
         check(16'(irq), 16'h0000, "irq after clear");
      end
      // Counter load, count rate and halt on channel 2
      a = 16'($urandom_range(16'hff00, 0));
      wrt(base(2), 16'h0000);
      wrt(base(2) + 8'h08, 16'hffff);
      wrt(base(2) + 8'h04, a);
      rdr(base(2) + 8'h04, got);
      check(got, a, "counter load");
      run(2, 1'b1);
      rdr(base(2) + 8'h04, got);
      repeat (78) @(posedge mclk);
      rdr(base(2) + 8'h04, a);
      check(a - got, 16'h000a, "ticks in 80 cycles");
      wrt(base(2) + 8'h04, 16'h0000);
      rdr(base(2) + 8'h04, got);
      check(16'(got > 16'h0001), 16'h0000, "restart from zero");
      run(2, 1'b0);
      rdr(base(2) + 8'h04, got);
      repeat (600) @(posedge mclk);
      rdr(base(2) + 8'h04, a);
      check(a, got, "halted counter holds");
      // Partner state after all traffic
      check(16'(pend), 16'h0000, "pending accepted");
      check(16'(grp), 16'h0001, "group flag sticky");
      check(16'(taken == 8'h00), 16'h0000, "requests accepted");
      complete_run;
   end
endmodule
